// ### bench/mri_core_model.sv
// ----------------------------------------
// Processor side of the opcode handshake
// ----------------------------------------
// The model flags a negative command code as an error, so the error path is reached.
// The model answers command 20 with a two-byte reply.
module mri_core_model #(
	parameter int DLY = 6
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire mri_pkg::mri_op_t op_out,
	input wire logic op_strobe,
	input wire logic meter_reset,
	output logic op_done,
	output logic op_error,
	output logic reply_valid,
	output mri_pkg::mri_reply_t reply_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import mri_pkg::*;
	int cnt;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 0;
		end else if (meter_reset) begin
			cnt <= 0;
		end else if (op_strobe) begin
			cnt <= DLY;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	assign op_done = (cnt == 1);
	assign op_error = (cnt == 1) && !op_out.is_param && op_out.code[7];
	assign reply_valid = (cnt == 1) && (op_out == 9'h020);
	// Away from the pulse the reply bus shows inverted data, so a stale sample is caught.
	assign reply_in = reply_valid ? {2'h2, 24'h00A5C3} : {2'h1, 24'hFF5A3C};
endmodule // mri_core_model

// ### bench/mri_regs_test.sv
module mri_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	import mri_pkg::*;
	logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, sample_armed = 0, conv_start = 0;
	logic conv_use_aperture = 0, selftest_run = 0, selftest_extended = 0, selftest_fail = 0;
	logic buf_nonempty = 0, op_strobe, op_done, op_error, reply_valid, meter_reset, sysfail_o;
	logic sysfail_oe, sample_strobe, buf_pop, pop_seen, smp_seen;
	logic [5:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0, buf_word = 0, reg_rdata, s;
	logic [23:0] aperture_cycles = 0;
	mri_op_t op_out;
	mri_reply_t reply_in;
	int n_fail = 0, samples_checked = 0, cyc = 0;
	always #10 ref_clk = ~ref_clk;
	mri_regs #(.CONV_CYC(20)) uut (.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata, .op_out, .op_strobe, .op_done, .op_error, .meter_reset, .sysfail_o,
		.sysfail_oe, .sample_armed, .sample_strobe, .conv_start, .conv_use_aperture,
		.aperture_cycles, .selftest_run, .selftest_extended, .selftest_fail, .reply_valid,
		.reply_in, .buf_nonempty, .buf_word, .buf_pop);
	mri_core_model core (.ref_clk, .sys_rst, .op_out, .op_strobe, .meter_reset, .op_done,
		.op_error, .reply_valid, .reply_in);
	// ----------------------------------------
	// Access, check and verdict tasks
	// ----------------------------------------
	task automatic chk(logic [15:0] g, logic [15:0] e, logic [15:0] m);
		samples_checked++;
		if ((g & m) !== (e & m)) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g & m, e & m);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge ref_clk);
		#2;
	endtask
	// Each access leaves one idle edge, so a strobe is never raised where it was lowered.
	task automatic wr(logic [5:0] a, logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		tick(1);
		reg_wr = 0;
		smp_seen = sample_strobe;
		tick(1);
	endtask
	task automatic rd(logic [5:0] a, output logic [15:0] d);
		reg_addr = a;
		reg_rd = 1;
		tick(1);
		reg_rd = 0;
		d = reg_rdata;
		pop_seen = buf_pop;
		tick(1);
	endtask
	// Done is only trusted once write-ready is seen with it.
	task automatic wait_done;
		for (int i = 0; i < 40; i++) begin
			rd(6'h04, s);
			if (s[0] === 1'b1 && s[7] === 1'b1) break;
		end
	endtask
	task automatic give_verdict;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			give_verdict();
		end
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		tick(16);
		sys_rst = 0;
		tick(110);
		rd(6'h04, s); chk(s, 16'hFF05, 16'hFF05);
		rd(6'h00, s); chk(s, 16'hF5A3, 16'hFFFF);
		rd(6'h02, s); chk(s, 16'h1C2D, 16'hFFFF);
		rd(6'h3E, s); chk(s, 16'hFFFF, 16'hFFFF);
		$display("test identity ended");
		wr(6'h08, 16'h3C04); rd(6'h04, s); chk(s, 16'h0000, 16'h0081);
		chk({7'h0, op_out}, 16'h0004, 16'h01FF);
		wait_done; chk(s, 16'h00C1, 16'h00C1);
		wr(6'h0A, 16'hFF7F); chk({7'h0, op_out}, 16'h017F, 16'h01FF);
		wait_done;
		wr(6'h08, 16'h0080); wait_done; chk(s, 16'h0081, 16'h00C1);
		wr(6'h08, 16'h0004); wait_done; chk(s, 16'h00C1, 16'h00C1);
		wr(6'h08, 16'h0020); wait_done; chk(s, 16'h0002, 16'h0002);
		rd(6'h08, s); chk(s, 16'hFFA5, 16'hFFFF);
		rd(6'h08, s); chk(s, 16'hFFC3, 16'hFFFF);
		rd(6'h04, s); chk(s, 16'h0000, 16'h0002);
		$display("test opcodes ended");
		sample_armed = 1;
		wr(6'h04, 16'h0004); chk({15'h0, smp_seen}, 16'h0001, 16'h0001);
		sample_armed = 0;
		wr(6'h04, 16'h0004); chk({15'h0, smp_seen}, 16'h0000, 16'h0001);
		for (int k = 0; k < 2; k++) begin
			conv_use_aperture = k[0];
			aperture_cycles = 24'd60;
			conv_start = 1;
			tick(1);
			conv_start = 0;
			tick(1);
			rd(6'h04, s); chk(s, 16'h0020, 16'h0020);
			tick(20);
			rd(6'h04, s); chk(s, k ? 16'h0020 : 16'h0000, 16'h0020);
			tick(50);
			rd(6'h04, s); chk(s, 16'h0000, 16'h0020);
		end
		$display("test sample ended");
		buf_word = 16'h8E31;
		buf_nonempty = 1;
		tick(3);
		rd(6'h04, s); chk(s, 16'h0010, 16'h0010);
		rd(6'h0C, s); chk(s, 16'h8E31, 16'hFFFF);
		chk({15'h0, pop_seen}, 16'h0001, 16'h0001);
		rd(6'h04, s); chk(s, 16'h0000, 16'h0010);
		buf_nonempty = 0;
		tick(2);
		rd(6'h04, s); chk(s, 16'h0000, 16'h0010);
		$display("test data ended");
		wr(6'h04, 16'h0000);
		selftest_run = 1;
		tick(3);
		rd(6'h04, s); chk(s, 16'h0008, 16'h000C);
		chk({14'h0, sysfail_o, sysfail_oe}, 16'h0001, 16'h0003);
		selftest_extended = 1;
		tick(1);
		rd(6'h04, s); chk(s, 16'h0004, 16'h000C);
		chk({14'h0, sysfail_o, sysfail_oe}, 16'h0001, 16'h0003);
		selftest_fail = 1;
		tick(1);
		selftest_fail = 0;
		selftest_run = 0;
		selftest_extended = 0;
		tick(3);
		chk({14'h0, sysfail_o, sysfail_oe}, 16'h0001, 16'h0003);
		rd(6'h04, s); chk(s, 16'h0000, 16'h0004);
		wr(6'h04, 16'h0002); tick(2); chk({15'h0, sysfail_oe}, 16'h0000, 16'h0001);
		wr(6'h04, 16'h0003); tick(110);
		chk({15'h0, meter_reset}, 16'h0001, 16'h0001);
		wr(6'h04, 16'h0002); tick(60); chk({15'h0, meter_reset}, 16'h0001, 16'h0001);
		tick(60); chk({15'h0, meter_reset}, 16'h0000, 16'h0001);
		rd(6'h04, s); chk(s, 16'h0005, 16'h0005);
		wr(6'h04, 16'h0000); tick(3); chk({15'h0, sysfail_oe}, 16'h0000, 16'h0001);
		$display("test selftest ended");
		give_verdict();
	end
endmodule // mri_regs_test

// ### hw/mri_map.svh
`ifndef MRI_MAP_SVH
`define MRI_MAP_SVH
`define MRI_CLK_NS 20
`define MRI_OFS_ID 6'h00
`define MRI_OFS_MODEL 6'h02
`define MRI_OFS_CTRL 6'h04
`define MRI_OFS_CMD 6'h08
`define MRI_OFS_PARM 6'h0A
`define MRI_OFS_DATA 6'h0C
`define MRI_CTL_RST 0
`define MRI_CTL_SFDIS 1
`define MRI_CTL_SAMP 2
`define MRI_ID_CLASS 2'h3
`define MRI_ID_AMODE 2'h3
`define MRI_ST_HIGH 8'hFF
`define MRI_RD_FILL 8'hFF
`define MRI_RST_NS 2000
`define MRI_RST_CYC ((`MRI_RST_NS + `MRI_CLK_NS - 1) / `MRI_CLK_NS)
`define MRI_CONV_US 400
`define MRI_CONV_CYC (`MRI_CONV_US * 1000 / `MRI_CLK_NS)
`endif

// ### hw/mri_pkg.sv
package mri_pkg;
	typedef enum logic [2:0] {
		MRI_IDLE = 3'b001,
		MRI_PROC = 3'b010,
		MRI_RESET = 3'b100
	} mri_state_t;
	typedef struct packed {
		logic is_param;
		logic [7:0] code;
	} mri_op_t;
	typedef struct packed {
		logic [1:0] nbytes;
		logic [23:0] value;
	} mri_reply_t;
	typedef struct packed {
		logic done;
		logic error_free_flag;
		logic conversion_active_flag;
		logic data_ready;
		logic not_extended;
		logic reset_selftest_ok;
		logic query_reply_available;
		logic opcode_write_ready;
	} mri_status_t;
endpackage

// ### hw/mri_regs.sv
// How it works
// [RULE1] Control bit 0 holds device in reset.
// [RULE2] Control bit 1 blocks driving SYSFAIL.
// [RULE3] SYSFAIL during self-test and after failure.
// [RULE4] Host disables SYSFAIL then resets failed device.
// [RULE5] Control bit 2 fires one sample.
// [RULE6] Opcodes in low byte at 08, 0A.
// [RULE7] Host sends two's complement opcodes.
// [RULE8] Checked errors clear error-free flag.
// [RULE9] Host waits for processing before next command.
// [RULE10] Identity class field reads 11.
// [RULE11] Identity addressing field reads 11.
// [RULE12] Identity low twelve bits: manufacturer code.
// [RULE13] Model word returns fixed code.
// [RULE14] Done bit low while processing.
// [RULE15] Error-free flag restored by next command.
// [RULE16] Conversion flag held for conversion time.
// [RULE17] Data ready tracks buffer, clears on read.
// [RULE18] Extended self-test: bit3 zero, bit2 one.
// [RULE19] Bit 2 low during reset or test.
// [RULE20] Reply flag set until reply read.
// [RULE21] Write-ready clears on each accepted opcode.
// [RULE22] Done and flags qualified by precedence.
// [RULE23] Host holds reset at least 2 us.
// [RULE24] Wide replies read out MSB first.
// [RULE25] Status upper byte reads all ones.
`include "mri_map.svh"

module mri_regs #(
	// Arbitrary code, not a real maker's.
	parameter logic [11:0] MFR_ID = 12'h5A3,
	// Arbitrary code, not a real part's.
	parameter logic [15:0] MODEL_ID = 16'h1C2D,
	parameter int CONV_CYC = `MRI_CONV_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [5:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output mri_pkg::mri_op_t op_out,
	output logic op_strobe,
	input wire logic op_done,
	input wire logic op_error,
	output logic meter_reset,
	output logic sysfail_o,
	output logic sysfail_oe,
	input wire logic sample_armed,
	output logic sample_strobe,
	input wire logic conv_start,
	input wire logic conv_use_aperture,
	input wire logic [23:0] aperture_cycles,
	input wire logic selftest_run,
	input wire logic selftest_extended,
	input wire logic selftest_fail,
	input wire logic reply_valid,
	input wire mri_pkg::mri_reply_t reply_in,
	input wire logic buf_nonempty,
	input wire logic [15:0] buf_word,
	output logic buf_pop
);
	import mri_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	localparam logic [7:0] RST_CYC = 8'(`MRI_RST_CYC);
	mri_state_t state_q, state_d;
	logic ctl_rst_q, ctl_rst_d, sf_dis_q, sf_dis_d, fail_q, fail_d;
	logic [7:0] rst_cnt_q, rst_cnt_d;
	logic [23:0] conv_cnt_q, conv_cnt_d;
	logic done_q, done_d, efree_q, efree_d, drdy_q, drdy_d;
	mri_reply_t rep_q, rep_d;
	mri_op_t op_q, op_d;
	logic op_stb_q, op_stb_d, samp_q, samp_d, pop_q, pop_d;
	logic mrst_q, mrst_d, sfoe_q, sfoe_d;
	logic [15:0] rdata_q, rdata_d;
	mri_status_t st;
	logic wr_ctrl, wr_op, rd_reply, rd_data, resetting;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		wr_ctrl = reg_wr && reg_addr == `MRI_OFS_CTRL;
		// Upper byte of the opcode ports is ignored on purpose.
		wr_op = reg_wr && (reg_addr == `MRI_OFS_CMD || reg_addr == `MRI_OFS_PARM); // [RULE6]
		rd_reply = reg_rd && reg_addr == `MRI_OFS_CMD;
		rd_data = reg_rd && reg_addr == `MRI_OFS_DATA;
		ctl_rst_d = wr_ctrl ? reg_wdata[`MRI_CTL_RST] : ctl_rst_q;
		sf_dis_d = wr_ctrl ? reg_wdata[`MRI_CTL_SFDIS] : sf_dis_q;
		// Reset keeps reloading while the bit is set, then runs out the minimum time.
		if (ctl_rst_d) begin
			rst_cnt_d = RST_CYC; // [RULE1]
		end else if (rst_cnt_q != 8'h00) begin
			rst_cnt_d = rst_cnt_q - 8'h01;
		end else begin
			rst_cnt_d = rst_cnt_q;
		end
		resetting = ctl_rst_q || rst_cnt_q != 8'h00;
		mrst_d = ctl_rst_d || rst_cnt_d != 8'h00; // [RULE1]
		// A failure arriving with a reset still latches.
		fail_d = selftest_fail || (fail_q && !ctl_rst_q); // [RULE3]
		sfoe_d = !sf_dis_d && (selftest_run || fail_d); // [RULE2] [RULE3]
		samp_d = wr_ctrl && reg_wdata[`MRI_CTL_SAMP] && sample_armed && !resetting; // [RULE5]
		state_d = state_q;
		op_d = op_q;
		op_stb_d = 1'b0;
		done_d = done_q;
		efree_d = efree_q;
		case (state_q)
			MRI_RESET: begin
				if (!resetting) begin
					state_d = MRI_IDLE;
				end
			end
			MRI_IDLE: begin
				// Writes while not ready are dropped; the host is expected to poll bit 0.
				if (wr_op) begin
					state_d = MRI_PROC; // [RULE21]
					op_d.is_param = reg_addr == `MRI_OFS_PARM;
					op_d.code = reg_wdata[7:0];
					op_stb_d = 1'b1;
					done_d = 1'b0; // [RULE14]
					if (reg_addr == `MRI_OFS_CMD) begin
						efree_d = 1'b1; // [RULE15]
					end
				end
			end
			MRI_PROC: begin
				if (op_done) begin
					state_d = MRI_IDLE;
					done_d = 1'b1; // [RULE14]
				end
			end
			default: state_d = MRI_RESET;
		endcase
		// An error in the same cycle as a new command wins over the restore.
		if (op_error) begin
			efree_d = 1'b0; // [RULE8] [RULE15]
		end
		if (conv_start) begin
			conv_cnt_d = conv_use_aperture ? aperture_cycles : 24'(CONV_CYC); // [RULE16]
		end else if (conv_cnt_q != 24'h000000) begin
			conv_cnt_d = conv_cnt_q - 24'h000001;
		end else begin
			conv_cnt_d = conv_cnt_q;
		end
		drdy_d = buf_nonempty && !rd_data && !pop_q; // [RULE17]
		rep_d = rep_q;
		if (reply_valid) begin
			rep_d.nbytes = reply_in.nbytes;
			case (reply_in.nbytes)
				2'd1: rep_d.value = {reply_in.value[7:0], 16'h0000};
				2'd2: rep_d.value = {reply_in.value[15:0], 8'h00};
				default: rep_d.value = reply_in.value;
			endcase
		end else if (rd_reply && rep_q.nbytes != 2'd0) begin
			rep_d.value = {rep_q.value[15:0], 8'h00}; // [RULE24]
			rep_d.nbytes = rep_q.nbytes - 2'd1; // [RULE20]
		end
		pop_d = rd_data;
		if (resetting) begin
			state_d = MRI_RESET;
			op_stb_d = 1'b0;
			done_d = 1'b1;
			efree_d = 1'b1;
			conv_cnt_d = 24'h000000;
			drdy_d = 1'b0;
			rep_d = '0;
		end
		st.done = done_q;
		st.error_free_flag = efree_q;
		st.conversion_active_flag = conv_cnt_q != 24'h000000; // [RULE16]
		st.data_ready = drdy_q;
		st.not_extended = !(selftest_run && selftest_extended); // [RULE18]
		// An extended test keeps bit 2 high, else bit 3 low could never mark it.
		st.reset_selftest_ok = !(resetting || (selftest_run && !selftest_extended) || fail_q); // [RULE19]
		st.query_reply_available = rep_q.nbytes != 2'd0; // [RULE20]
		st.opcode_write_ready = state_q == MRI_IDLE; // [RULE21] [RULE22]
		rdata_d = rdata_q;
		if (reg_rd) begin
			if (reg_addr == `MRI_OFS_ID) begin
				rdata_d = {`MRI_ID_CLASS, `MRI_ID_AMODE, MFR_ID}; // [RULE10] [RULE11] [RULE12]
			end else if (reg_addr == `MRI_OFS_MODEL) begin
				rdata_d = MODEL_ID; // [RULE13]
			end else if (reg_addr == `MRI_OFS_CTRL) begin
				rdata_d = {`MRI_ST_HIGH, st}; // [RULE25]
			end else if (reg_addr == `MRI_OFS_CMD) begin
				rdata_d = {`MRI_RD_FILL, rep_q.value[23:16]}; // [RULE24]
			end else if (reg_addr == `MRI_OFS_DATA) begin
				rdata_d = buf_word;
			end else begin
				rdata_d = 16'hFFFF;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= MRI_RESET;
			ctl_rst_q <= 1'b0;
			sf_dis_q <= 1'b0;
			fail_q <= 1'b0;
			rst_cnt_q <= RST_CYC;
			conv_cnt_q <= 24'h000000;
			done_q <= 1'b1;
			efree_q <= 1'b1;
			drdy_q <= 1'b0;
			rep_q <= '0;
			op_q <= '0;
			op_stb_q <= 1'b0;
			samp_q <= 1'b0;
			pop_q <= 1'b0;
			mrst_q <= 1'b1;
			sfoe_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			ctl_rst_q <= ctl_rst_d;
			sf_dis_q <= sf_dis_d;
			fail_q <= fail_d;
			rst_cnt_q <= rst_cnt_d;
			conv_cnt_q <= conv_cnt_d;
			done_q <= done_d;
			efree_q <= efree_d;
			drdy_q <= drdy_d;
			rep_q <= rep_d;
			op_q <= op_d;
			op_stb_q <= op_stb_d;
			samp_q <= samp_d;
			pop_q <= pop_d;
			mrst_q <= mrst_d;
			sfoe_q <= sfoe_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign op_out = op_q;
	assign op_strobe = op_stb_q;
	assign meter_reset = mrst_q;
	// The line is open drain and active low; only the enable moves.
	assign sysfail_o = 1'b0;
	assign sysfail_oe = sfoe_q;
	assign sample_strobe = samp_q;
	assign buf_pop = pop_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reset_held: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE1]
		ctl_rst_q |=> meter_reset) else $error("reset not held while control bit set");
	a_sysfail_off: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE2]
		sf_dis_q |-> !sysfail_oe) else $error("sysfail driven while disabled");
	a_sysfail_test: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE3]
		(selftest_run && !sf_dis_d) |=> sysfail_oe) else $error("sysfail missing in self-test");
	a_sample_once: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE5]
		sample_strobe |-> $past(reg_wr && reg_addr == `MRI_OFS_CTRL
		&& reg_wdata[`MRI_CTL_SAMP] && sample_armed)) else $error("sample strobe without a write");
	a_id_word: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE10]
		(reg_rd && reg_addr == `MRI_OFS_ID) |=> reg_rdata[15:12] == 4'hF)
		else $error("identity class or mode wrong");
	a_model_word: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE13]
		(reg_rd && reg_addr == `MRI_OFS_MODEL) |=> reg_rdata == MODEL_ID)
		else $error("model word wrong");
	a_ready_drop: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE21]
		(wr_op && state_q == MRI_IDLE && !resetting) |=> !st.opcode_write_ready && op_strobe
		&& !done_q) else $error("opcode accept did not clear ready and done");
	a_error_flag: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE8]
		(op_error && !resetting) |=> !efree_q) else $error("error did not clear flag");
	a_reply_drain: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE20]
		(rd_reply && rep_q.nbytes == 2'd1 && !reply_valid && !resetting)
		|=> !st.query_reply_available) else $error("reply flag not cleared");
	a_status_high: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE25]
		(reg_rd && reg_addr == `MRI_OFS_CTRL) |=> reg_rdata[15:8] == 8'hFF)
		else $error("status upper byte not all ones");
	a_passed_low: assert property (@(posedge ref_clk) disable iff (sys_rst) // [RULE19]
		meter_reset |-> !st.reset_selftest_ok) else $error("passed set during reset");
endmodule // mri_regs
